/* shared/sf_decoder_map.vh */
// Purpose: constants for the serial flash read and resume decoder
// Assumes: opcodes and phase lengths as seen on the serial pins
// Notes:   definitions only, included by bare name
`ifndef SF_DECODER_MAP_VH
`define SF_DECODER_MAP_VH

// instruction codes
`define OP_READ        8'h03
`define OP_FAST_READ   8'h0B
`define OP_DUAL_OUT    8'h3B
`define OP_QUAD_OUT    8'h6B
`define OP_DUAL_IO     8'hBB
`define OP_QUAD_IO     8'hEB
`define OP_SUSPEND     8'h75
`define OP_RESUME      8'h7A

// frame geometry in bits and clocks
`define OPCODE_BITS    5'h08
`define ADDR_BITS      24
`define MODE_BITS      8
`define FAST_DUMMY     5'h08
`define QIO_DUMMY_DEF  4
`define CONT_SELECT    2'b10

// pin enables, low while driving; single mode drives data_line_1 only
`define OE_NONE        4'hf
`define OE_SINGLE      4'hd
`define OE_DUAL        4'hc
`define OE_QUAD        4'h0

`endif

/* design/serial_flash_read_resume_decoder.v */
// Purpose: serial command decoder for read, suspend and resume instructions
// Assumes: serial clock at most one eighth of clk_i; memory answers combinationally
// Notes:   all serial pins pass two flip-flops; sclk edges found in the clk_i domain
`include "sf_decoder_map.vh"
`timescale 1ns/10ps
`default_nettype none

module serial_flash_read_resume_decoder #(
    parameter QIO_DUMMY = `QIO_DUMMY_DEF
) (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        chip_select_n_i,
    input  wire        serial_clock_i,
    input  wire [3:0]  data_line_i,
    output reg  [3:0]  data_line_o,
    output reg  [3:0]  data_line_oe_n_o,
    input  wire        quad_enable_flag_i,
    input  wire        op_start_i,
    input  wire        op_done_i,
    output wire        suspended_flag_o,
    output wire        busy_flag_o,
    output reg         suspend_req_o,
    output reg         resume_req_o,
    output wire [23:0] mem_addr_o,
    input  wire [7:0]  mem_data_i,
    output wire [7:0]  continuous_mode_byte_o
);
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_CMD   = 3'd1;
    localparam [2:0] ST_ADDR  = 3'd2;
    localparam [2:0] ST_MODE  = 3'd3;
    localparam [2:0] ST_DUMMY = 3'd4;
    localparam [2:0] ST_DATA  = 3'd5;
    localparam [2:0] ST_SYS   = 3'd6;
    localparam [2:0] ST_IGN   = 3'd7;
    reg  [2:0]  cs_s_q;
    reg  [2:0]  sck_s_q;
    reg  [3:0]  dl1_q;
    reg  [3:0]  dl2_q;
    reg  [2:0]  st_q;
    reg  [7:0]  op_q;
    reg  [4:0]  cnt_q;
    reg  [23:0] in_sh_q;
    reg  [23:0] addr_q;
    reg  [7:0]  out_sh_q;
    reg  [2:0]  bcnt_q;
    reg  [7:0]  mode_q;
    reg         cont_q;
    reg         susp_q;
    reg         busy_q;
    wire cs_fall  = cs_s_q[2] & ~cs_s_q[1];
    wire cs_rise  = ~cs_s_q[2] & cs_s_q[1];
    wire sck_rise = ~cs_s_q[1] & ~sck_s_q[2] & sck_s_q[1];
    wire sck_fall = ~cs_s_q[1] & sck_s_q[2] & ~sck_s_q[1];
    assign suspended_flag_o       = susp_q;
    assign busy_flag_o            = busy_q;
    assign mem_addr_o             = addr_q;
    assign continuous_mode_byte_o = mode_q;
    // lanes per clock for address and data, and phase lengths, by opcode
    reg [2:0] addr_w;
    reg [2:0] data_w;
    reg [4:0] addr_clk;
    reg [4:0] mode_clk;
    reg [4:0] dummy_clk;
    reg [3:0] oe_data;
    reg       op_known;
    reg       needs_qe;
    always @* begin
        addr_w    = 3'd1;
        data_w    = 3'd1;
        addr_clk  = 5'd24;
        mode_clk  = 5'd0;
        dummy_clk = 5'd0;
        oe_data   = `OE_SINGLE;
        op_known  = 1'b1;
        needs_qe  = 1'b0;
        case (op_q)
            `OP_READ:      op_known  = 1'b1;
            `OP_FAST_READ: dummy_clk = `FAST_DUMMY;
            `OP_DUAL_OUT: begin
                data_w    = 3'd2;
                dummy_clk = `FAST_DUMMY;
                oe_data   = `OE_DUAL;
            end
            `OP_QUAD_OUT: begin
                data_w    = 3'd4;
                dummy_clk = `FAST_DUMMY;
                oe_data   = `OE_QUAD;
                needs_qe  = 1'b1;
            end
            `OP_DUAL_IO: begin
                addr_w    = 3'd2;
                data_w    = 3'd2;
                addr_clk  = 5'd12;
                mode_clk  = 5'd4;
                oe_data   = `OE_DUAL;
            end
            `OP_QUAD_IO: begin
                addr_w    = 3'd4;
                data_w    = 3'd4;
                addr_clk  = 5'd6;
                mode_clk  = 5'd2;
                dummy_clk = QIO_DUMMY[4:0];
                oe_data   = `OE_QUAD;
                needs_qe  = 1'b1;
            end
            default:       op_known  = 1'b0;
        endcase
    end

    // sample lanes of the input for the current width
    function [23:0] shift_in;
        input [23:0] sh;
        input [2:0]  w;
        input [3:0]  d;
        begin
            case (w)
                3'd4:    shift_in = {sh[19:0], d};
                3'd2:    shift_in = {sh[21:0], d[1:0]};
                default: shift_in = {sh[22:0], d[0]};
            endcase
        end
    endfunction

    // place the top bits of a byte onto the lanes of the current width
    function [3:0] lanes_out;
        input [7:0] b;
        input [2:0] w;
        begin
            case (w)
                3'd4:    lanes_out = b[7:4];
                3'd2:    lanes_out = {2'b00, b[7:6]};
                default: lanes_out = {2'b00, b[7], 1'b0};   // single bit rides line 1
            endcase
        end
    endfunction

    wire [23:0] in_next = shift_in(in_sh_q, (st_q == ST_CMD) ? 3'd1 : addr_w, dl2_q);
    // two-flop synchronisers; stage 3 of cs and sck only feeds edge detection
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_s_q  <= 3'b111;
            sck_s_q <= 3'b000;
            dl1_q   <= 4'h0;
            dl2_q   <= 4'h0;
        end else begin
            cs_s_q  <= {cs_s_q[1:0], chip_select_n_i};
            sck_s_q <= {sck_s_q[1:0], serial_clock_i};
            dl1_q   <= data_line_i;
            dl2_q   <= dl1_q;
        end
    end

    // frame sequencer, flags and output shifter
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q             <= ST_IDLE;
            op_q             <= 8'h00;
            cnt_q            <= 5'd0;
            in_sh_q          <= 24'h00_0000;
            addr_q           <= 24'h00_0000;
            out_sh_q         <= 8'h00;
            bcnt_q           <= 3'd0;
            mode_q           <= 8'hff;
            cont_q           <= 1'b0;
            susp_q           <= 1'b0;
            busy_q           <= 1'b0;
            suspend_req_o    <= 1'b0;
            resume_req_o     <= 1'b0;
            data_line_o      <= 4'h0;
            data_line_oe_n_o <= `OE_NONE;
        end else begin
            suspend_req_o <= 1'b0;
            resume_req_o  <= 1'b0;
            // sequencer start sets busy and wins over its own done
            if (op_start_i) begin
                busy_q <= 1'b1;
            end else if (op_done_i) begin
                busy_q <= 1'b0;
            end
            if (cs_fall) begin
                cnt_q   <= 5'd0;
                in_sh_q <= 24'h00_0000;
                if (cont_q) begin
                    st_q <= busy_q ? ST_IGN : ST_ADDR;      // opcode kept from last read
                end else begin
                    st_q <= ST_CMD;
                end
            end else if (cs_rise) begin
                // chip select high ends any stream and frees the lines
                st_q             <= ST_IDLE;
                data_line_oe_n_o <= `OE_NONE;
                if (st_q == ST_SYS && op_q == `OP_SUSPEND && !susp_q && busy_q) begin
                    susp_q        <= 1'b1;
                    busy_q        <= 1'b0;
                    suspend_req_o <= 1'b1;
                end
                // accepted resume: suspended drops and busy rises on the same edge
                if (st_q == ST_SYS && op_q == `OP_RESUME && susp_q && !busy_q) begin
                    susp_q       <= 1'b0;
                    busy_q       <= 1'b1;
                    resume_req_o <= 1'b1;
                end
            end else if (sck_rise) begin
                cnt_q   <= cnt_q + 5'd1;
                in_sh_q <= in_next;
                case (st_q)
                    ST_CMD: begin
                        if (cnt_q == `OPCODE_BITS - 5'd1) begin
                            op_q    <= in_next[7:0];
                            cnt_q   <= 5'd0;
                            in_sh_q <= 24'h00_0000;
                            if (in_next[7:0] == `OP_SUSPEND || in_next[7:0] == `OP_RESUME) begin
                                st_q <= ST_SYS;
                            end else begin
                                st_q <= busy_q ? ST_IGN : ST_ADDR;
                            end
                        end
                    end
                    ST_ADDR: begin
                        // unknown opcodes and quad reads without enable drop out here
                        if (!op_known || (needs_qe && !quad_enable_flag_i)) begin
                            st_q <= ST_IGN;
                        end else if (cnt_q == addr_clk - 5'd1) begin
                            addr_q  <= in_next;
                            cnt_q   <= 5'd0;
                            in_sh_q <= 24'h00_0000;
                            bcnt_q  <= 3'd0;
                            if (mode_clk != 5'd0) begin
                                st_q <= ST_MODE;
                            end else if (dummy_clk != 5'd0) begin
                                st_q <= ST_DUMMY;
                            end else begin
                                st_q <= ST_DATA;
                            end
                        end
                    end
                    ST_MODE: begin
                        // low nibble is taken but never steers anything
                        if (cnt_q == mode_clk - 5'd1) begin
                            mode_q    <= in_next[7:0];
                            cont_q    <= (in_next[5:4] == `CONT_SELECT);
                            cnt_q     <= 5'd0;
                            st_q      <= (dummy_clk != 5'd0) ? ST_DUMMY : ST_DATA;
                        end
                    end
                    ST_DUMMY: begin
                        // input lines carry nothing of use here
                        if (cnt_q == dummy_clk - 5'd1) begin
                            cnt_q <= 5'd0;
                            st_q  <= ST_DATA;
                        end
                    end
                    ST_IDLE, ST_DATA, ST_SYS, ST_IGN: cnt_q <= 5'd0;
                    default: st_q <= ST_IDLE;
                endcase
            end else if (sck_fall && st_q == ST_DATA) begin
                // fetch a fresh byte at each byte boundary, then walk its bits
                data_line_oe_n_o <= oe_data;
                if (bcnt_q == 3'd0) begin
                    data_line_o <= lanes_out(mem_data_i, data_w);
                    out_sh_q    <= mem_data_i << data_w;
                    addr_q      <= addr_q + 24'h00_0001;
                    bcnt_q      <= (3'd7 / data_w) - 3'd0;
                end else begin
                    data_line_o <= lanes_out(out_sh_q, data_w);
                    out_sh_q    <= out_sh_q << data_w;
                    bcnt_q      <= bcnt_q - 3'd1;
                end
            end
        end
    end

endmodule // serial_flash_read_resume_decoder

`default_nettype wire

/* tb/sf_read_chk.sv */
// Purpose: port checker for the serial flash read and resume decoder
// Assumes: sclk levels last at least four clk_i cycles
// Notes:   bound to the decoder top, watches its ports only
`timescale 1ns/10ps
`default_nettype none
module sf_read_chk (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        chip_select_n_i,
    input wire logic        serial_clock_i,
    input wire logic [3:0]  data_line_o,
    input wire logic [3:0]  data_line_oe_n_o,
    input wire logic        quad_enable_flag_i,
    input wire logic        suspended_flag_o,
    input wire logic        busy_flag_o,
    input wire logic        suspend_req_o,
    input wire logic        resume_req_o,
    input wire logic [23:0] mem_addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // flag handshakes of suspend and resume
    a_resume_gate: assert property (resume_req_o |-> $past(suspended_flag_o) && !$past(busy_flag_o))
        else $error("resume taken in wrong state");
    a_resume_flags: assert property (resume_req_o |-> !suspended_flag_o && busy_flag_o)
        else $error("resume left flags wrong");
    a_resume_once: assert property (resume_req_o |=> !resume_req_o)
        else $error("resume pulse too long");
    a_suspend_gate: assert property (suspend_req_o |-> $past(busy_flag_o) && !$past(suspended_flag_o) && suspended_flag_o && !busy_flag_o)
        else $error("suspend handled wrongly");
    // pin behaviour; a late release would fight the next owner of the bus
    a_cs_release: assert property (chip_select_n_i [*6] |-> data_line_oe_n_o == 4'hf)
        else $error("lines driven after deselect");
    a_quad_gate: assert property (data_line_oe_n_o == 4'h0 |-> quad_enable_flag_i)
        else $error("quad drive without enable");
    a_data_on_fall: assert property ($changed(data_line_o) && $past(data_line_oe_n_o) != 4'hf && data_line_oe_n_o != 4'hf |-> !serial_clock_i)
        else $error("data moved outside low clock");
    a_addr_step: assert property ($changed(mem_addr_o) && $past(data_line_oe_n_o) != 4'hf && !chip_select_n_i |-> mem_addr_o == $past(mem_addr_o) + 24'h00_0001)
        else $error("address did not step by one");
    c_resume: cover property (resume_req_o);
    c_suspend: cover property (suspend_req_o);
    c_quad: cover property (data_line_oe_n_o == 4'h0);
endmodule // sf_read_chk
bind serial_flash_read_resume_decoder sf_read_chk chk (.clk_i, .rst_n_i, .chip_select_n_i,
    .serial_clock_i, .data_line_o, .data_line_oe_n_o, .quad_enable_flag_i, .suspended_flag_o,
    .busy_flag_o, .suspend_req_o, .resume_req_o, .mem_addr_o);
`default_nettype wire

/* tb/spi_host_model.sv */
// Purpose: host controller model for the serial flash pins
// Assumes: ten clk_i cycles per serial clock, sclk idles low
// Notes:   released lines are pulled up
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] dev_i,
    input  wire logic [3:0] dev_oe_n_i,
    output logic            cs_n_o,
    output logic            sclk_o,
    output logic [3:0]      line_o
);
    logic [3:0] drv_q;
    logic [3:0] en_q;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        drv_q = 4'h0;
        en_q = 4'h0;
    end
    // wire level: device, else host, else pull-up
    always_comb for (int i = 0; i < 4; i++) line_o[i] = !dev_oe_n_i[i] ? dev_i[i] : en_q[i] ? drv_q[i] : 1'b1;
    task hold(); repeat (5) @(negedge clk_i); endtask
    task start(); cs_n_o = 1'b0; hold(); endtask
    // long gap after each frame, so no suspend ever follows a resume early
    task stop(); en_q = 4'h0; cs_n_o = 1'b1; repeat (20) @(negedge clk_i); endtask
    // one serial clock: settle, sample, rise, hold, fall
    task pulse(output logic [3:0] s); hold(); s = line_o; sclk_o = 1'b1; hold(); sclk_o = 1'b0; endtask
    task send(input logic [31:0] v, input int n, input int w);
        logic [3:0] s;
        en_q = w == 1 ? 4'h1 : w == 2 ? 4'h3 : 4'hf;
        for (int i = n - 1; i >= 0; i--) begin
            drv_q = 4'(v >> (i * w));
            pulse(s);
        end
    endtask
    // dummies and low mode bits left undriven, lines free before data
    task idle(input int n); logic [3:0] s; en_q = 4'h0; repeat (n) pulse(s); endtask
    task recv(output logic [7:0] b, input int w);
        logic [3:0] s;
        en_q = 4'h0;
        b = 8'h00;
        repeat (8 / w) begin
            pulse(s);
            b = w == 1 ? {b[6:0], s[1]} : w == 2 ? {b[5:0], s[1:0]} : {b[3:0], s};
        end
    endtask
endmodule // spi_host_model
`default_nettype wire

/* tb/serial_flash_read_resume_decoder_bench.sv */
// Purpose: self-checking bench for the read and resume decoder
// Assumes: memory contents are a fixed pattern of the address
// Notes:   serial pins come from the host model
`timescale 1ns/10ps
`default_nettype none
`include "sf_decoder_map.vh"
module serial_flash_read_resume_decoder_bench;
    logic clk_i = 0, rst_n_i = 0, qe = 1, op_start = 0, op_done = 0, cs_n, sclk, suspended_flag, busy;
    logic [3:0]  din, dout, oe_n;
    logic [23:0] addr;
    logic [7:0]  mode;
    int mismatches = 0, compares = 0;
    always #5 clk_i = ~clk_i;
    function automatic logic [7:0] pat(input logic [23:0] a); return a[7:0] ^ a[15:8] ^ 8'ha5; endfunction
    serial_flash_read_resume_decoder dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n),
        .serial_clock_i(sclk), .data_line_i(din), .data_line_o(dout), .data_line_oe_n_o(oe_n),
        .quad_enable_flag_i(qe), .op_start_i(op_start), .op_done_i(op_done), .suspended_flag_o(suspended_flag),
        .busy_flag_o(busy), .suspend_req_o(), .resume_req_o(), .mem_addr_o(addr),
        .mem_data_i(pat(addr)), .continuous_mode_byte_o(mode));
    spi_host_model h (.clk_i(clk_i), .dev_i(dout), .dev_oe_n_i(oe_n), .cs_n_o(cs_n), .sclk_o(sclk), .line_o(din));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one read frame of two bytes; refused frames must leave lines released
    task rd(input logic [7:0] op, input logic [23:0] a, input int aw, input int dw, input int dm,
            input logic [7:0] m, input bit op_on, input bit ok);
        logic [7:0] b;
        h.start();
        if (op_on) h.send(op, 8, 1);
        h.send(a, 24 / aw, aw);
        // continuous frames leave the low mode nibble undriven, so pull-ups fill it
        if (aw > 1 && op_on) h.send(m, 8 / aw, aw);
        else if (aw > 1) begin
            h.send(m >> 4, 4 / aw, aw);
            h.idle(4 / aw);
        end
        h.idle(dm);
        for (int i = 0; i < 2; i++) begin
            h.recv(b, dw);
            if (ok) chk(b, pat(24'(a + i)));
        end
        chk(oe_n, !ok ? 4'hf : dw == 1 ? 4'hd : dw == 2 ? 4'hc : 4'h0);
        h.stop();
        chk(oe_n, 4'hf);
    endtask
    task cmd(input logic [7:0] op); h.start(); h.send(op, 8, 1); h.stop(); endtask
    task t_flags();
        cmd(`OP_RESUME);
        chk({suspended_flag, busy}, 2'b00);
        @(negedge clk_i) op_start = 1;
        @(negedge clk_i) op_start = 0;
        cmd(`OP_RESUME);
        chk({suspended_flag, busy}, 2'b01);
        cmd(`OP_SUSPEND);
        chk({suspended_flag, busy}, 2'b10);
        rd(`OP_READ, 24'h01_0000, 1, 1, 0, 8'h00, 1, 1);
        cmd(`OP_RESUME);
        chk({suspended_flag, busy}, 2'b01);
        rd(`OP_READ, 24'h01_0000, 1, 1, 0, 8'h00, 1, 0);
        chk({suspended_flag, busy}, 2'b01);
        @(negedge clk_i) op_done = 1;
        @(negedge clk_i) op_done = 0;
    endtask
    task t_single();
        rd(`OP_READ, 24'hff_ffff, 1, 1, 0, 8'h00, 1, 1);
        rd(`OP_FAST_READ, 24'h00_1234, 1, 1, 8, 8'h00, 1, 1);
        rd(`OP_DUAL_OUT, 24'h12_3456, 1, 2, 8, 8'h00, 1, 1);
        rd(`OP_QUAD_OUT, 24'h0a_bcde, 1, 4, 8, 8'h00, 1, 1);
    endtask
    task t_quad_off();
        qe = 0;
        rd(`OP_QUAD_OUT, 24'h00_0100, 1, 4, 8, 8'h00, 1, 0);
        rd(`OP_QUAD_IO, 24'h00_0100, 4, 4, 4, 8'h20, 1, 0);
        qe = 1;
    endtask
    task t_dual_io();
        rd(`OP_DUAL_IO, 24'h33_3333, 2, 2, 0, 8'h2c, 1, 1);
        chk(mode, 8'h2c);
        rd(`OP_DUAL_IO, 24'h44_0ff0, 2, 2, 0, 8'h27, 0, 1);
        chk(mode, 8'h2f);
        h.start();
        h.send(32'h0000_ffff, 16, 1);
        h.stop();
        chk(mode, 8'hff);
        rd(`OP_READ, 24'h00_0042, 1, 1, 0, 8'h00, 1, 1);
    endtask
    task t_quad_io();
        rd(`OP_QUAD_IO, 24'h55_aaa0, 4, 4, 4, 8'h25, 1, 1);
        rd(`OP_QUAD_IO, 24'h66_0001, 4, 4, 4, 8'hf0, 0, 1);
        rd(`OP_READ, 24'h00_0077, 1, 1, 0, 8'h00, 1, 1);
    endtask
    // flags, line enables, address and mode byte at idle values after reset, the mid-run one included
    task t_reset();
        rst_n_i = 0;
        repeat (16) @(negedge clk_i);
        rst_n_i = 1;
        repeat (4) @(negedge clk_i);
        chk({suspended_flag, busy}, 2'b00);
        chk(oe_n, 4'hf);
        chk({addr, mode}, 32'h0000_00ff);
    endtask
    // watchdog well beyond the expected run of about 6500 cycles
    initial begin
        #500_000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        t_reset();
        t_flags();
        t_single();
        t_quad_off();
        t_dual_io();
        // busy set and address moved, so the second reset has state to clear
        @(negedge clk_i) op_start = 1;
        @(negedge clk_i) op_start = 0;
        t_reset();
        t_quad_io();
        report_and_stop();
    end
endmodule // serial_flash_read_resume_decoder_bench
`default_nettype wire
